/* design/pfc_checker.sv */
// protection and fault checking beside instruction execution
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - protected-only op in real mode faults 6
// - real mode code/data past ffffh faults 13
// - real mode stack past limit faults 12
// - exchange with memory always locks bus
// - lock held on descriptor table accesses
// - protected limit/rights faults 13, stack limit 12
// - segment load privilege 13, not-present 11/12
// - cross-segment transfer privilege break faults 13
// - ring-zero ops fault 13 above level 0
// - io-sensitive ops fault 13 above io level
// - flags load filters if, io level, vm
// - status word load never clears protection
// - verify privilege failure clears zero flag
// - escape operand faults 13, stack start 12
// - transfer target beyond code limit faults 13
// - xor clears of/cf, sets sf/zf/pf
module pfc_checker (
  input wire logic clk_sys,
  input wire logic reset,
  // instruction check request
  input wire logic chk_valid,
  input wire pfc_pkg::pfc_op_t chk_op,
  input wire logic [7:0] chk_opcode,
  input wire logic chk_mem_op,
  input wire logic chk_stack_seg,
  input wire logic [31:0] chk_offset,
  input wire logic [2:0] chk_size_m1,
  input wire logic [31:0] chk_seg_limit,
  input wire logic chk_rights_ok,
  input wire logic [1:0] chk_rpl,
  input wire logic [1:0] chk_dpl,
  input wire logic chk_present,
  input wire logic chk_xfer_far,
  input wire logic chk_xfer_priv_ok,
  input wire logic [31:0] chk_target,
  input wire logic [31:0] chk_code_limit,
  input wire logic chk_desc_access,
  input wire logic [31:0] chk_data,
  input wire logic [31:0] chk_result,
  // results
  output logic commit_ok,
  output logic fault_valid,
  output logic [7:0] fault_vector,
  output logic lock_active,
  output logic [31:0] flags_out,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  // ----------------------------------------
  // architectural state
  // ----------------------------------------
  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] msw_r;
  logic [1:0] cpl_r;
  logic [7:0] vec_r;
  logic [7:0] vec_nxt;
  logic fault_det;
  logic lock_r;
  logic [31:0] fault_cnt_r;
  pfc_pkg::pfc_state_t state_r;

  logic prot_mode;
  logic [1:0] io_priv_level;
  logic [32:0] end_addr;
  logic [32:0] first_end;
  logic [32:0] lim_ext;
  logic limit_bad;
  logic first_bad;
  logic priv_bad;
  logic verify_fail;

  assign prot_mode = msw_r[pfc_pkg::PFC_CTRL_PE_BIT];
  assign io_priv_level = flags_r[pfc_pkg::PFC_FL_IO_PRIV_LEVEL_LSB +: 2];
  assign end_addr = {1'b0, chk_offset} + {30'h0, chk_size_m1};
  assign first_end = {1'b0, chk_offset};
  // real mode uses the fixed 64k limit for every segment
  assign lim_ext = prot_mode ? {1'b0, chk_seg_limit} : {1'b0, pfc_pkg::PFC_REAL_LIMIT};
  assign limit_bad = chk_mem_op && (end_addr > lim_ext);
  assign first_bad = chk_mem_op && (first_end > lim_ext);
  // rpl or cpl weaker than dpl, or wrong rights, refuses the load
  assign priv_bad = (chk_rpl > chk_dpl) || (cpl_r > chk_dpl) || !chk_rights_ok;
  assign verify_fail = priv_bad;

  // ----------------------------------------
  // fault selection, first match wins
  // ----------------------------------------
  always_comb begin
    fault_det = 1'b0;
    vec_nxt = pfc_pkg::PFC_VEC_GP;
    if (chk_valid) begin
      if (!prot_mode && chk_op == pfc_pkg::PFC_OP_PMODE_ONLY) begin
        fault_det = 1'b1;
        vec_nxt = pfc_pkg::PFC_VEC_UD;
      end else if (chk_op == pfc_pkg::PFC_OP_ESC && chk_mem_op) begin
        if (chk_stack_seg && first_bad) begin
          fault_det = 1'b1;
          vec_nxt = pfc_pkg::PFC_VEC_SS;
        end else if (!chk_stack_seg && (limit_bad || (prot_mode && !chk_rights_ok))) begin
          fault_det = 1'b1;
          vec_nxt = pfc_pkg::PFC_VEC_GP;
        end
      end else if (chk_op != pfc_pkg::PFC_OP_VERIFY && limit_bad) begin
        fault_det = 1'b1;
        vec_nxt = chk_stack_seg ? pfc_pkg::PFC_VEC_SS : pfc_pkg::PFC_VEC_GP;
      end else if (prot_mode && chk_mem_op && !chk_rights_ok && chk_op != pfc_pkg::PFC_OP_VERIFY
                   && chk_op != pfc_pkg::PFC_OP_SEG_LOAD) begin
        fault_det = 1'b1;
        vec_nxt = pfc_pkg::PFC_VEC_GP;
      end else if (prot_mode) begin
        case (chk_op)
          // status word and control register moves are ring-zero only as well,
          // otherwise an outer ring could drop out of protected mode
          pfc_pkg::PFC_OP_RING0, pfc_pkg::PFC_OP_MSW_LOAD, pfc_pkg::PFC_OP_CR0_MOVE: begin
            fault_det = (cpl_r != 2'h0);
          end
          pfc_pkg::PFC_OP_IO_SENS: begin
            fault_det = (cpl_r > io_priv_level);
          end
          pfc_pkg::PFC_OP_SEG_LOAD: begin
            if (priv_bad) begin
              fault_det = 1'b1;
            end else if (!chk_present) begin
              fault_det = 1'b1;
              vec_nxt = chk_stack_seg ? pfc_pkg::PFC_VEC_SS : pfc_pkg::PFC_VEC_NP;
            end
          end
          pfc_pkg::PFC_OP_XFER: begin
            fault_det = (chk_xfer_far && !chk_xfer_priv_ok)
                        || (chk_target > chk_code_limit);
          end
          default: begin
            fault_det = 1'b0;
          end
        endcase
      end else if (chk_op == pfc_pkg::PFC_OP_XFER) begin
        fault_det = (chk_target > chk_code_limit);
      end
    end
  end

  // a faulting instruction never reaches the commit stage
  assign commit_ok = chk_valid && !fault_det;

  // ----------------------------------------
  // flags update on commit
  // ----------------------------------------
  always_comb begin
    flags_nxt = flags_r;
    if (commit_ok) begin
      case (chk_op)
        pfc_pkg::PFC_OP_FLAGS_LOAD: begin
          flags_nxt = chk_data | pfc_pkg::PFC_FLAGS_RST;
          if (prot_mode && cpl_r > io_priv_level) begin
            flags_nxt[pfc_pkg::PFC_FL_IF] = flags_r[pfc_pkg::PFC_FL_IF];
          end
          if (prot_mode && cpl_r != 2'h0) begin
            flags_nxt[pfc_pkg::PFC_FL_IO_PRIV_LEVEL_LSB +: 2] = io_priv_level;
            flags_nxt[pfc_pkg::PFC_FL_VM] = flags_r[pfc_pkg::PFC_FL_VM];
          end
        end
        pfc_pkg::PFC_OP_VERIFY: begin
          flags_nxt[pfc_pkg::PFC_FL_ZF] = !verify_fail;
        end
        pfc_pkg::PFC_OP_XOR: begin
          // auxiliary carry is left as is, software must not rely on it
          flags_nxt[pfc_pkg::PFC_FL_OF] = 1'b0;
          flags_nxt[pfc_pkg::PFC_FL_CF] = 1'b0;
          flags_nxt[pfc_pkg::PFC_FL_SF] = chk_result[31];
          flags_nxt[pfc_pkg::PFC_FL_ZF] = (chk_result == 32'h0);
          flags_nxt[pfc_pkg::PFC_FL_PF] = ~^chk_result[7:0];
        end
        default: begin
          flags_nxt = flags_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flags_r <= pfc_pkg::PFC_FLAGS_RST;
    end else if (reg_wr && reg_addr == pfc_pkg::PFC_OFS_FLAGS) begin
      flags_r <= reg_wdata | pfc_pkg::PFC_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------
  // machine status word and privilege level
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      msw_r <= pfc_pkg::PFC_MSW_RST;
    end else if (commit_ok && chk_op == pfc_pkg::PFC_OP_MSW_LOAD) begin
      msw_r <= {msw_r[31:16], chk_data[15:1], chk_data[0] | msw_r[0]};
    end else if (commit_ok && chk_op == pfc_pkg::PFC_OP_CR0_MOVE) begin
      msw_r <= chk_data;
    end else if (reg_wr && reg_addr == pfc_pkg::PFC_OFS_MSW) begin
      msw_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cpl_r <= 2'h0;
    end else if (reg_wr && reg_addr == pfc_pkg::PFC_OFS_CTRL) begin
      cpl_r <= reg_wdata[pfc_pkg::PFC_CTRL_CPL_LSB +: 2];
    end
  end

  // ----------------------------------------
  // bus lock
  // ----------------------------------------
  // registered so the lock covers the whole bus cycle that follows
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= chk_valid && ((chk_op == pfc_pkg::PFC_OP_EXCHANGE && chk_mem_op)
                || chk_desc_access);
    end
  end
  assign lock_active = lock_r;

  // ----------------------------------------
  // fault dispatch
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= pfc_pkg::PFC_ST_IDLE;
      vec_r <= 8'h00;
    end else begin
      case (state_r)
        pfc_pkg::PFC_ST_IDLE: begin
          if (fault_det) begin
            state_r <= pfc_pkg::PFC_ST_FAULT;
            vec_r <= vec_nxt;
          end
        end
        pfc_pkg::PFC_ST_FAULT: begin
          state_r <= pfc_pkg::PFC_ST_DISPATCH;
        end
        pfc_pkg::PFC_ST_DISPATCH: begin
          state_r <= pfc_pkg::PFC_ST_IDLE;
        end
        default: begin
          state_r <= pfc_pkg::PFC_ST_IDLE;
        end
      endcase
    end
  end
  assign fault_valid = (state_r == pfc_pkg::PFC_ST_FAULT);
  assign fault_vector = vec_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fault_cnt_r <= 32'h0;
    end else if (reg_wr && reg_addr == pfc_pkg::PFC_OFS_STATUS) begin
      // a fault in the clearing cycle is still counted
      fault_cnt_r <= (state_r == pfc_pkg::PFC_ST_FAULT) ? 32'h1 : 32'h0;
    end else if (state_r == pfc_pkg::PFC_ST_FAULT) begin
      fault_cnt_r <= fault_cnt_r + 32'h1;
    end
  end

  assign flags_out = flags_r;

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        pfc_pkg::PFC_OFS_CTRL: reg_rdata <= {29'h0, cpl_r, prot_mode};
        pfc_pkg::PFC_OFS_STATUS: reg_rdata <= {fault_cnt_r[23:0], vec_r};
        pfc_pkg::PFC_OFS_MSW: reg_rdata <= msw_r;
        pfc_pkg::PFC_OFS_FLAGS: reg_rdata <= flags_r;
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule // pfc_checker
`default_nettype wire

/* design/pfc_pkg.sv */
// package of constants and types for the protection fault checker
package pfc_pkg;
  // ----------------------------------------
  // register offsets (word addresses)
  // ----------------------------------------
  localparam logic [3:0] PFC_OFS_CTRL = 4'h0;
  localparam logic [3:0] PFC_OFS_STATUS = 4'h1;
  localparam logic [3:0] PFC_OFS_MSW = 4'h2;
  localparam logic [3:0] PFC_OFS_FLAGS = 4'h3;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PFC_CTRL_PE_BIT = 0;
  localparam int PFC_CTRL_CPL_LSB = 1;
  localparam int PFC_FL_CF = 0;
  localparam int PFC_FL_PF = 2;
  localparam int PFC_FL_AF = 4;
  localparam int PFC_FL_ZF = 6;
  localparam int PFC_FL_SF = 7;
  localparam int PFC_FL_IF = 9;
  localparam int PFC_FL_OF = 11;
  localparam int PFC_FL_IO_PRIV_LEVEL_LSB = 12;
  localparam int PFC_FL_VM = 17;
  // ----------------------------------------
  // reset values, limits, vectors
  // ----------------------------------------
  localparam logic [31:0] PFC_FLAGS_RST = 32'h0000_0002;
  localparam logic [31:0] PFC_MSW_RST = 32'h0000_0000;
  localparam logic [31:0] PFC_REAL_LIMIT = 32'h0000_ffff;
  localparam logic [7:0] PFC_VEC_UD = 8'h06;
  localparam logic [7:0] PFC_VEC_NP = 8'h0b;
  localparam logic [7:0] PFC_VEC_SS = 8'h0c;
  localparam logic [7:0] PFC_VEC_GP = 8'h0d;
  localparam logic [7:0] PFC_XOR_RR_HI = 8'h30;
  localparam logic [7:0] PFC_XOR_RR_MASK = 8'hfc;
  // ----------------------------------------
  // instruction classes presented by decode
  // ----------------------------------------
  typedef enum logic [3:0] {
    PFC_OP_PLAIN = 4'h0,
    PFC_OP_PMODE_ONLY = 4'h1,
    PFC_OP_RING0 = 4'h2,
    PFC_OP_IO_SENS = 4'h3,
    PFC_OP_SEG_LOAD = 4'h4,
    PFC_OP_XFER = 4'h5,
    PFC_OP_FLAGS_LOAD = 4'h6,
    PFC_OP_MSW_LOAD = 4'h7,
    PFC_OP_CR0_MOVE = 4'h8,
    PFC_OP_VERIFY = 4'h9,
    PFC_OP_ESC = 4'ha,
    PFC_OP_EXCHANGE = 4'hb,
    PFC_OP_XOR = 4'hc
  } pfc_op_t;
  typedef enum logic [2:0] {
    PFC_ST_IDLE = 3'b001,
    PFC_ST_FAULT = 3'b010,
    PFC_ST_DISPATCH = 3'b100
  } pfc_state_t;
endpackage : pfc_pkg

/* tb/pfc_checker_sva.sv */
// concurrent checks on the protection fault checker ports
`timescale 1ns/1ps
`default_nettype none
module pfc_checker_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic chk_valid,
  input wire pfc_pkg::pfc_op_t chk_op,
  input wire logic chk_mem_op,
  input wire logic chk_stack_seg,
  input wire logic [31:0] chk_offset,
  input wire logic [2:0] chk_size_m1,
  input wire logic [31:0] chk_seg_limit,
  input wire logic [31:0] chk_target,
  input wire logic [31:0] chk_code_limit,
  input wire logic chk_desc_access,
  input wire logic [31:0] chk_result,
  input wire logic reg_wr,
  input wire logic commit_ok,
  input wire logic fault_valid,
  input wire logic [7:0] fault_vector,
  input wire logic lock_active,
  input wire logic [31:0] flags_out
);
  // ----------------------------------------
  // helper terms and properties
  // ----------------------------------------
  logic [32:0] end_w;
  logic ovr_w;
  logic [2:0] xor_w;
  assign end_w = {1'b0, chk_offset} + {30'h0, chk_size_m1};
  // past both limits, so the expected vector holds in either mode
  assign ovr_w = chk_valid && chk_mem_op && (chk_op == pfc_pkg::PFC_OP_PLAIN) &&
    (end_w > 33'h0_0000_ffff) && (end_w > {1'b0, chk_seg_limit});
  assign xor_w = {chk_result[31], chk_result == 32'h0, ~^chk_result[7:0]};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // faults seen in the pulse or dispatch cycle are dropped
  sequence s_ready;
    !fault_valid && !$past(fault_valid);
  endsequence
  sequence s_vec(logic [7:0] v);
    fault_valid && (fault_vector == v);
  endsequence
  property p_pulse; fault_valid |=> !fault_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("fault pulse too long");
  property p_cause; fault_valid |-> $past(chk_valid) && !$past(commit_ok); endproperty
  a_cause: assert property (p_cause) else $error("fault without aborted check");
  property p_lk_exchange_op;
    chk_valid && chk_op == pfc_pkg::PFC_OP_EXCHANGE && chk_mem_op |=> lock_active;
  endproperty
  a_lk_exchange_op: assert property (p_lk_exchange_op) else $error("exchange not locked");
  property p_lk_desc; chk_valid && chk_desc_access |=> lock_active; endproperty
  a_lk_desc: assert property (p_lk_desc) else $error("descriptor access not locked");
  property p_xfer;
    chk_valid && chk_op == pfc_pkg::PFC_OP_XFER && chk_target > chk_code_limit |-> !commit_ok;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer past limit committed");
  property p_data; s_ready ##0 (ovr_w && !chk_stack_seg) |=> s_vec(pfc_pkg::PFC_VEC_GP); endproperty
  a_data: assert property (p_data) else $error("data limit vector wrong");
  property p_stack; s_ready ##0 (ovr_w && chk_stack_seg) |=> s_vec(pfc_pkg::PFC_VEC_SS); endproperty
  a_stack: assert property (p_stack) else $error("stack limit vector wrong");
  property p_xor;
    chk_valid && chk_op == pfc_pkg::PFC_OP_XOR && commit_ok && !reg_wr |=> !flags_out[11] &&
      !flags_out[0] && {flags_out[7], flags_out[6], flags_out[2]} == $past(xor_w);
  endproperty
  a_xor: assert property (p_xor) else $error("xor flags wrong");
endmodule // pfc_checker_sva
bind pfc_checker pfc_checker_sva u_sva (.*);
`default_nettype wire

/* tb/tb_protection_fault_checker.sv */
// self-checking bench for the protection fault checker
`timescale 1ns/1ps
`default_nettype none
module tb_protection_fault_checker;
  logic clk_sys = 1'b0, reset = 1'b1, chk_valid = 1'b0, chk_mem_op, chk_stack_seg;
  logic chk_rights_ok, chk_present, chk_xfer_far = 1'b0, chk_xfer_priv_ok = 1'b1;
  logic chk_desc_access = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic commit_ok, fault_valid, lock_active;
  pfc_pkg::pfc_op_t chk_op = pfc_pkg::PFC_OP_PLAIN;
  logic [7:0] chk_opcode = pfc_pkg::PFC_XOR_RR_HI, fault_vector;
  logic [31:0] chk_offset, chk_seg_limit = 32'h0000_ffff, chk_target = 32'h0;
  logic [31:0] chk_code_limit = 32'hffff_ffff, chk_data = 32'h0, chk_result = 32'h0;
  logic [31:0] reg_wdata = 32'h0, flags_out, reg_rdata;
  logic [2:0] chk_size_m1;
  logic [1:0] chk_rpl, chk_dpl;
  logic [3:0] reg_addr = 4'h0;
  int bad_count = 0;
  int num_checks = 0;
  pfc_checker u_dut (.*);
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata === e, "register read");
  endtask
  // one check cycle, then the pulse and dispatch cycles are waited out
  task automatic rn(input pfc_pkg::pfc_op_t op, input logic [7:0] v, input logic lk);
    @(posedge clk_sys);
    chk_op <= op;
    chk_valid <= 1'b1;
    @(negedge clk_sys);
    chk(commit_ok === (v == 8'h00), "commit");
    @(posedge clk_sys);
    chk_valid <= 1'b0;
    @(negedge clk_sys);
    chk(fault_valid === (v != 8'h00) && (v == 8'h00 || fault_vector === v), "vector");
    chk(lock_active === lk, "lock");
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic sf(input logic mem, stk, input logic [31:0] off, input logic [2:0] sz,
      input logic ok, input logic [1:0] rp, dp, input logic pr);
    chk_mem_op <= mem;
    chk_stack_seg <= stk;
    chk_offset <= off;
    chk_size_m1 <= sz;
    chk_rights_ok <= ok;
    chk_rpl <= rp;
    chk_dpl <= dp;
    chk_present <= pr;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_real;
    rd(pfc_pkg::PFC_OFS_FLAGS, pfc_pkg::PFC_FLAGS_RST);
    rd(4'hf, 32'h0);
    rn(pfc_pkg::PFC_OP_PMODE_ONLY, pfc_pkg::PFC_VEC_UD, 1'b0);
    sf(1'b1, 1'b0, 32'h0000_fffe, 3'h3, 1'b1, 2'h0, 2'h0, 1'b1);
    rn(pfc_pkg::PFC_OP_PLAIN, pfc_pkg::PFC_VEC_GP, 1'b0);
    chk_stack_seg <= 1'b1;
    rn(pfc_pkg::PFC_OP_PLAIN, pfc_pkg::PFC_VEC_SS, 1'b0);
    sf(1'b1, 1'b0, 32'h0, 3'h0, 1'b1, 2'h0, 2'h0, 1'b1);
    rn(pfc_pkg::PFC_OP_EXCHANGE, 8'h00, 1'b1);
    chk_desc_access <= 1'b1;
    rn(pfc_pkg::PFC_OP_PLAIN, 8'h00, 1'b1);
    chk_desc_access <= 1'b0;
    // three faults so far, the last one a stack fault
    rd(pfc_pkg::PFC_OFS_STATUS, 32'h0000_030c);
    wr(pfc_pkg::PFC_OFS_STATUS, 32'h0);
    rd(pfc_pkg::PFC_OFS_STATUS, 32'h0000_000c);
  endtask
  task automatic t_prot;
    wr(pfc_pkg::PFC_OFS_MSW, 32'h1);
    wr(pfc_pkg::PFC_OFS_CTRL, 32'h6);
    rd(pfc_pkg::PFC_OFS_CTRL, 32'h0000_0007);
    rn(pfc_pkg::PFC_OP_RING0, pfc_pkg::PFC_VEC_GP, 1'b0);
    rn(pfc_pkg::PFC_OP_IO_SENS, pfc_pkg::PFC_VEC_GP, 1'b0);
    rn(pfc_pkg::PFC_OP_CR0_MOVE, pfc_pkg::PFC_VEC_GP, 1'b0);
    chk_data <= 32'h0002_3242;
    rn(pfc_pkg::PFC_OP_FLAGS_LOAD, 8'h00, 1'b0);
    rd(pfc_pkg::PFC_OFS_FLAGS, 32'h0000_0042);
    sf(1'b0, 1'b0, 32'h0, 3'h0, 1'b1, 2'h0, 2'h3, 1'b0);
    rn(pfc_pkg::PFC_OP_SEG_LOAD, pfc_pkg::PFC_VEC_NP, 1'b0);
    chk_stack_seg <= 1'b1;
    rn(pfc_pkg::PFC_OP_SEG_LOAD, pfc_pkg::PFC_VEC_SS, 1'b0);
    sf(1'b0, 1'b0, 32'h0, 3'h0, 1'b1, 2'h3, 2'h0, 1'b1);
    rn(pfc_pkg::PFC_OP_SEG_LOAD, pfc_pkg::PFC_VEC_GP, 1'b0);
    rn(pfc_pkg::PFC_OP_VERIFY, 8'h00, 1'b0);
    chk(flags_out[6] === 1'b0, "verify zero flag");
    sf(1'b1, 1'b0, 32'h0, 3'h0, 1'b0, 2'h0, 2'h0, 1'b1);
    rn(pfc_pkg::PFC_OP_PLAIN, pfc_pkg::PFC_VEC_GP, 1'b0);
    sf(1'b1, 1'b1, 32'h0000_0100, 3'h0, 1'b1, 2'h0, 2'h0, 1'b1);
    chk_seg_limit <= 32'h0000_00ff;
    rn(pfc_pkg::PFC_OP_ESC, pfc_pkg::PFC_VEC_SS, 1'b0);
    chk_stack_seg <= 1'b0;
    rn(pfc_pkg::PFC_OP_ESC, pfc_pkg::PFC_VEC_GP, 1'b0);
    sf(1'b0, 1'b0, 32'h0, 3'h0, 1'b1, 2'h0, 2'h0, 1'b1);
    chk_xfer_far <= 1'b1;
    chk_xfer_priv_ok <= 1'b0;
    rn(pfc_pkg::PFC_OP_XFER, pfc_pkg::PFC_VEC_GP, 1'b0);
    chk_xfer_far <= 1'b0;
    chk_target <= 32'h0000_0100;
    chk_code_limit <= 32'h0000_00ff;
    rn(pfc_pkg::PFC_OP_XFER, pfc_pkg::PFC_VEC_GP, 1'b0);
    wr(pfc_pkg::PFC_OFS_CTRL, 32'h0);
    chk_data <= 32'h0;
    rn(pfc_pkg::PFC_OP_MSW_LOAD, 8'h00, 1'b0);
    rd(pfc_pkg::PFC_OFS_MSW, 32'h1);
    rn(pfc_pkg::PFC_OP_CR0_MOVE, 8'h00, 1'b0);
    rd(pfc_pkg::PFC_OFS_MSW, 32'h0);
  endtask
  task automatic t_xor;
    wr(pfc_pkg::PFC_OFS_FLAGS, 32'h0000_0803);
    rn(pfc_pkg::PFC_OP_XOR, 8'h00, 1'b0);
    chk({flags_out[11], flags_out[7:6], flags_out[2], flags_out[0]} === 5'h06, "xor");
  endtask
  initial begin
    sf(1'b0, 1'b0, 32'h0, 3'h0, 1'b1, 2'h0, 2'h0, 1'b1);
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_real();
    t_prot();
    t_xor();
    report_and_stop();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
endmodule // tb_protection_fault_checker
`default_nettype wire
